// file: verilog/acs_consts.svh
// constants for the adc conversion sequencer: register map, fields, reset values, timing
// assumes inclusion from the package and the sequencer module only
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

// ============================================================
// register byte addresses
`define ACS_ADDR_CONFIG     4'h0
`define ACS_ADDR_RESULT     4'h4
`define ACS_ADDR_STATUS     4'h8
`define ACS_ADDR_W          4

// ============================================================
// config register fields
`define ACS_CFG_SEL_LSB     0
`define ACS_CFG_RATE_LSB    3
`define ACS_CFG_CONT_BIT    6
`define ACS_CFG_START_BIT   7
`define ACS_CFG_RESET       8'h20

// ============================================================
// timing: oscillator period, core clock period, modulator divide
`define ACS_OSC_PERIOD_NS   1000
`define ACS_CLK_PERIOD_NS   5
`define ACS_OSC_DIV         (`ACS_OSC_PERIOD_NS / `ACS_CLK_PERIOD_NS)
`define ACS_MOD_DIV         4

// conversion length in modulator periods per rate code (250 kHz / rate, rounded down)
`define ACS_MODS_128        12'h7A1
`define ACS_MODS_250        12'h3E8
`define ACS_MODS_490        12'h1FE
`define ACS_MODS_920        12'h10F
`define ACS_MODS_1600       12'h09C
`define ACS_MODS_2400       12'h068
`define ACS_MODS_3300       12'h04B

// filter normalising shift per rate code, brings full scale near 2048
`define ACS_SHIFT_128       3'h0
`define ACS_SHIFT_250       3'h1
`define ACS_SHIFT_490       3'h2
`define ACS_SHIFT_920       3'h3
`define ACS_SHIFT_1600      3'h4
`define ACS_SHIFT_2400      3'h4
`define ACS_SHIFT_3300      3'h5

`define ACS_CODE_MAX        13'h07FF
`define ACS_CODE_MIN        13'h1801

`endif

// file: verilog/acs_pkg.sv
// types shared by the adc conversion sequencer
// assumes acs_consts.svh is reachable by bare name on the include path
`include "acs_consts.svh"

package acs_pkg;

  // ============================================================
  // sequencer states
  typedef enum logic [1:0] {
    ACS_POWER_DOWN = 2'b00,
    ACS_CONVERTING = 2'b01,
    ACS_STORE      = 2'b10
  } acs_state_t;

  // ============================================================
  // configuration word
  typedef struct packed {
    logic       start;      // single-shot request, write-only pulse
    logic       continuous; // 1 continuous, 0 single-shot
    logic [2:0] rate;       // sample_rate_field
    logic [2:0] sel;        // input_select_field
  } acs_cfg_t;

  // ============================================================
  // analog front-end controls
  typedef struct packed {
    logic [3:0] pos_sel;    // one-hot analog input to positive_converter_input
    logic [3:0] neg_sel;    // one-hot analog input to negative_converter_input
    logic       neg_gnd;    // ties negative_converter_input to ground
  } acs_route_t;

  typedef struct packed {
    logic mod_clk;          // modulator_sample_clock
    logic sample_sw;        // sampling_switch_group closed
    logic discharge_sw;     // discharge_switch_group closed
  } acs_switch_t;

endpackage : acs_pkg

// file: verilog/acs_sequencer.sv
// conversion sequencer of a 12-bit delta-sigma adc: modes, filter, mux, switch timing
// assumes an axi4-lite master on core_clk_in and a modulator bit from the analog side
//
// Behaviour
// RULE1 - single-shot mode runs exactly one conversion per request and none otherwise.
// RULE2 - a finished single-shot conversion is written to the result register first.
// RULE3 - after storing a single-shot result the converter powers down until requested.
// RULE4 - continuous mode starts the next conversion as soon as one ends.
// RULE5 - continuous conversions complete at the programmed data rate.
// RULE6 - the result register is readable anytime and holds the last complete code.
// RULE7 - a three-bit input selection field in the config register picks the inputs.
// RULE8 - selections give four single-ended, two differential and inputs 0 and 1 versus 3.
// RULE9 - single-ended selections close the switch grounding the negative input.
// RULE10 - variants without mux always convert input zero against input one.
// RULE11 - the modulator clock is the 1 MHz oscillator divided by four, 250 kHz.
// RULE12 - the sampling switches close during the sampling phase.
// RULE13 - sampling switches open before discharge switches close, never both closed.
// RULE14 - the filter turns the one-bit stream into a 12-bit proportional code.
// RULE15 - rate codes select 128 to 3300 samples per second, one cycle settling.
// RULE16 - reset loads default configuration and leaves the converter powered down.
// RULE17 - the result register updates in a single clock cycle.

`include "acs_consts.svh"
module acs_sequencer #(
  parameter int unsigned OSC_DIV = `ACS_OSC_DIV, // core cycles per oscillator tick
  parameter bit          HAS_MUX = 1'b1          // 0 for variants without input mux
) (
  input  wire logic                 core_clk_in,     // 200 MHz core clock
  input  wire logic                 sys_rst_in,      // async reset, active high
  input  wire logic                 ce_in,           // clock enable, low freezes state
  input  wire logic                 mod_bit_in,      // modulator bitstream, async
  input  wire logic                 s_axi_awvalid,   // write address valid
  output logic                      s_axi_awready,   // write address ready
  input  wire logic [31:0]          s_axi_awaddr,    // write address
  input  wire logic                 s_axi_wvalid,    // write data valid
  output logic                      s_axi_wready,    // write data ready
  input  wire logic [31:0]          s_axi_wdata,     // write data
  input  wire logic [3:0]           s_axi_wstrb,     // write byte strobes
  output logic                      s_axi_bvalid,    // write response valid
  input  wire logic                 s_axi_bready,    // write response ready
  output logic [1:0]                s_axi_bresp,     // write response
  input  wire logic                 s_axi_arvalid,   // read address valid
  output logic                      s_axi_arready,   // read address ready
  input  wire logic [31:0]          s_axi_araddr,    // read address
  output logic                      s_axi_rvalid,    // read data valid
  input  wire logic                 s_axi_rready,    // read data ready
  output logic [31:0]               s_axi_rdata,     // read data
  output logic [1:0]                s_axi_rresp,     // read response
  output acs_pkg::acs_route_t       route_out,       // input mux controls
  output acs_pkg::acs_switch_t      switch_out,      // modulator clock and switches
  output logic                      converting_out   // converter powered and running
);

  // ============================================================
  // elaboration checks
  if (OSC_DIV < 1 || OSC_DIV > 65535)
  begin : g_bad_div
    $error("OSC_DIV out of range");
  end

  localparam logic [15:0] OSC_LAST = 16'(OSC_DIV - 1);

  // ============================================================
  // declarations
  acs_pkg::acs_state_t state_q;
  acs_pkg::acs_cfg_t   cfg_q;
  logic [2:0]          run_sel_q;
  logic [2:0]          run_rate_q;
  logic                pend_q;
  logic [11:0]         result_q;
  logic [15:0]         osc_cnt_q;
  logic                osc_tick;
  logic [1:0]          phase_q;
  logic [11:0]         mods_q;
  logic [11:0]         mods_len;
  logic [2:0]          norm_shift;
  logic signed [12:0]  acc_q;
  logic signed [20:0]  scaled;
  logic [12:0]         code;
  logic                mod_meta_q;
  logic                mod_sync_q;
  logic                mod_end;
  logic                conv_done;
  logic                aw_got_q;
  logic                w_got_q;
  logic [`ACS_ADDR_W-1:0] aw_addr_q;
  logic [31:0]         w_data_q;
  logic [3:0]          w_strb_q;
  logic                wr_fire;
  logic                start_req;
  logic [31:0]         rd_word;
  logic                rd_ok;

  // ============================================================
  // modulator bit synchroniser, second stage alone feeds the filter
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      {mod_sync_q, mod_meta_q} <= 2'b00;
    else if (ce_in)
      {mod_sync_q, mod_meta_q} <= {mod_meta_q, mod_bit_in};
  end

  // ============================================================
  // oscillator tick: 200 core cycles make one 1 MHz period
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      osc_cnt_q <= 16'h0000;
    else if (ce_in)
      osc_cnt_q <= osc_tick ? 16'h0000 : osc_cnt_q + 16'h0001;
  end

  assign osc_tick = (osc_cnt_q == OSC_LAST);

  // modulator phase: four oscillator ticks per 250 kHz period
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      phase_q <= 2'b00;
    else if (ce_in && state_q != acs_pkg::ACS_CONVERTING)
      phase_q <= 2'b00;
    else if (ce_in && osc_tick)
      phase_q <= phase_q + 2'b01; // RULE11
  end

  assign mod_end = osc_tick && (phase_q == 2'(`ACS_MOD_DIV - 1));

  // ============================================================
  // switch timing: sample in phases 0-1, gap in 2, discharge in 3
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      switch_out <= '0;
    else if (ce_in)
    begin
      switch_out.mod_clk      <= (state_q == acs_pkg::ACS_CONVERTING) && !phase_q[1]; // RULE11
      switch_out.sample_sw    <= (state_q == acs_pkg::ACS_CONVERTING) && !phase_q[1]; // RULE12
      // the dead phase guarantees a full tick with both groups open
      switch_out.discharge_sw <= (state_q == acs_pkg::ACS_CONVERTING)
                                 && (phase_q == 2'b11); // RULE13
    end
  end

  // ============================================================
  // conversion length and filter scale per rate code
  always_comb
  begin
    case (run_rate_q) // RULE15
      3'h0:    {mods_len, norm_shift} = {`ACS_MODS_128, `ACS_SHIFT_128};
      3'h1:    {mods_len, norm_shift} = {`ACS_MODS_250, `ACS_SHIFT_250};
      3'h2:    {mods_len, norm_shift} = {`ACS_MODS_490, `ACS_SHIFT_490};
      3'h3:    {mods_len, norm_shift} = {`ACS_MODS_920, `ACS_SHIFT_920};
      3'h4:    {mods_len, norm_shift} = {`ACS_MODS_1600, `ACS_SHIFT_1600};
      3'h5:    {mods_len, norm_shift} = {`ACS_MODS_2400, `ACS_SHIFT_2400};
      default: {mods_len, norm_shift} = {`ACS_MODS_3300, `ACS_SHIFT_3300}; // 6, 7: top rate
    endcase
  end

  assign conv_done = mod_end && (mods_q == mods_len - 12'h001); // RULE5

  // ============================================================
  // filter: up/down count of the bitstream, normalised and clipped to 12 bits
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      {acc_q, mods_q} <= 25'h000_0000;
    else if (ce_in && state_q != acs_pkg::ACS_CONVERTING)
      {acc_q, mods_q} <= 25'h000_0000;
    else if (ce_in && mod_end)
    begin
      acc_q  <= mod_sync_q ? acc_q + 13'sh0001 : acc_q - 13'sh0001; // RULE14
      mods_q <= mods_q + 12'h001;
    end
  end

  assign scaled = 21'(acc_q) <<< norm_shift;
  assign code   = (scaled > 21'(signed'(`ACS_CODE_MAX))) ? `ACS_CODE_MAX :
                  (scaled < 21'(signed'(`ACS_CODE_MIN))) ? `ACS_CODE_MIN :
                  scaled[12:0]; // RULE14

  // ============================================================
  // sequencer state machine
  assign start_req = pend_q;

  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state_q    <= acs_pkg::ACS_POWER_DOWN; // RULE16
      run_sel_q  <= 3'h0;
      run_rate_q <= 3'h0;
    end
    else if (ce_in)
    begin
      case (state_q)
        acs_pkg::ACS_POWER_DOWN:
        begin
          if (cfg_q.continuous || start_req) // RULE1
          begin
            state_q    <= acs_pkg::ACS_CONVERTING;
            run_sel_q  <= cfg_q.sel;
            run_rate_q <= cfg_q.rate;
          end
        end
        acs_pkg::ACS_CONVERTING:
        begin
          if (conv_done)
            state_q <= acs_pkg::ACS_STORE; // RULE2
        end
        acs_pkg::ACS_STORE:
        begin
          // result was written on entry to this state; choose next conversion or sleep
          if (cfg_q.continuous || start_req) // RULE4
          begin
            state_q    <= acs_pkg::ACS_CONVERTING;
            run_sel_q  <= cfg_q.sel;
            run_rate_q <= cfg_q.rate;
          end
          else
            state_q <= acs_pkg::ACS_POWER_DOWN; // RULE3
        end
        default:
          state_q <= acs_pkg::ACS_POWER_DOWN;
      endcase
    end
  end

  assign converting_out = (state_q == acs_pkg::ACS_CONVERTING);

  // result held in the converting cycle's filter, copied whole in one edge
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      result_q <= 12'h000;
    else if (ce_in && conv_done)
      result_q <= code[11:0]; // RULE2 RULE17
  end

  // ============================================================
  // input routing, registered from the selection latched at start
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      route_out <= '0;
    else if (ce_in && !HAS_MUX)
      route_out <= {4'h1, 4'h2, 1'b0}; // RULE10
    else if (ce_in)
    begin
      // fields in order: positive select, negative select, ground tie
      case (run_sel_q) // RULE7 RULE8
        3'h0:    route_out <= {4'h1, 4'h2, 1'b0};
        3'h1:    route_out <= {4'h1, 4'h8, 1'b0};
        3'h2:    route_out <= {4'h2, 4'h8, 1'b0};
        3'h3:    route_out <= {4'h4, 4'h8, 1'b0};
        default: route_out <= {4'(4'h1 << run_sel_q[1:0]), 4'h0, 1'b1}; // RULE9
      endcase
    end
  end

  // ============================================================
  // axi4-lite write side: address and data taken in either order
  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
  assign s_axi_bresp   = 2'b00;
  assign wr_fire       = aw_got_q && w_got_q && !s_axi_bvalid;

  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      {aw_got_q, w_got_q, aw_addr_q, w_data_q, w_strb_q, s_axi_bvalid} <= '0;
    else if (ce_in)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_q  <= 1'b1;
        aw_addr_q <= s_axi_awaddr[`ACS_ADDR_W-1:0];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_q  <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1; // unmapped writes still answer okay; only address bits 3:0 are decoded, so ones with those bits zero write config
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // config register; start bit is a request, not stored
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      cfg_q <= `ACS_CFG_RESET; // RULE16
    else if (ce_in && wr_fire && aw_addr_q == `ACS_ADDR_CONFIG && w_strb_q[0])
    begin
      cfg_q.sel        <= HAS_MUX ? w_data_q[`ACS_CFG_SEL_LSB +: 3] : 3'h0; // RULE7 RULE10
      cfg_q.rate       <= w_data_q[`ACS_CFG_RATE_LSB +: 3]; // RULE15
      cfg_q.continuous <= w_data_q[`ACS_CFG_CONT_BIT];
      cfg_q.start      <= 1'b0;
    end
  end

  // pending single-shot request; a new request wins over the consuming clear
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      pend_q <= 1'b0;
    else if (ce_in && wr_fire && aw_addr_q == `ACS_ADDR_CONFIG && w_strb_q[0]
             && w_data_q[`ACS_CFG_START_BIT])
      pend_q <= 1'b1; // RULE1
    else if (ce_in && pend_q && (state_q == acs_pkg::ACS_POWER_DOWN
                                 || state_q == acs_pkg::ACS_STORE))
      pend_q <= 1'b0;
  end

  // ============================================================
  // axi4-lite read side: one read at a time, answered the cycle after
  assign s_axi_arready = !s_axi_rvalid;

  always_comb
  begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    case (s_axi_araddr[`ACS_ADDR_W-1:0])
      `ACS_ADDR_CONFIG:
        rd_word = {24'h00_0000, pend_q || converting_out, cfg_q.continuous,
                   cfg_q.rate, cfg_q.sel};
      `ACS_ADDR_RESULT:
        rd_word = {20'h0_0000, result_q}; // RULE6
      `ACS_ADDR_STATUS:
        rd_word = {28'h000_0000, pend_q, 1'b0, state_q};
      default:
        rd_ok = 1'b0;
    endcase
    if (s_axi_araddr[31:`ACS_ADDR_W] != '0)
      rd_ok = 1'b0;
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      {s_axi_rvalid, s_axi_rdata, s_axi_rresp} <= '0;
    else if (ce_in)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_ok ? rd_word : 32'h0000_0000;
        s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10; // slverr on unmapped address
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // acs_sequencer

// file: verif/acs_sequencer_asserts.sv
// checker of the sequencer port behaviour, bound onto acs_sequencer
// assumes one core clock and the active-high async reset of the design
module acs_seq_chk #(
  parameter int unsigned OSC_DIV = 200 // core cycles per oscillator tick
) (
  input wire logic                 core_clk_in,    // core clock
  input wire logic                 sys_rst_in,     // async reset
  input wire logic                 s_axi_awvalid,  // aw valid
  input wire logic                 s_axi_awready,  // aw ready
  input wire logic                 s_axi_wvalid,   // w valid
  input wire logic                 s_axi_wready,   // w ready
  input wire logic                 s_axi_bvalid,   // b valid
  input wire logic                 s_axi_arvalid,  // ar valid
  input wire logic                 s_axi_arready,  // ar ready
  input wire logic                 s_axi_rvalid,   // r valid
  input wire acs_pkg::acs_route_t  route_out,      // mux controls
  input wire acs_pkg::acs_switch_t switch_out,     // switch controls
  input wire logic                 converting_out  // converting
);
  timeunit 1ns;
  timeprecision 1ps;
  // ============================================================
  // helper counters
  logic [15:0] per_q;
  logic [31:0] run_q;
  logic        mclk_q;
  logic        seen_q;
  logic        rise;

  // rising edge of the modulator clock, seen from the registered copy
  assign rise = switch_out.mod_clk & ~mclk_q;

  // period is only judged between two rises of one conversion, the first rise has no reference
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      mclk_q <= 1'b0;
      per_q  <= 16'h0000;
      seen_q <= 1'b0;
      run_q  <= 32'h0000_0000;
    end
    else
    begin
      mclk_q <= switch_out.mod_clk;
      per_q  <= rise ? 16'h0001 : per_q + 16'h0001;
      seen_q <= converting_out & (seen_q | rise);
      run_q  <= converting_out ? run_q + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  // ============================================================
  // properties
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  AST_SW_APART: assert property (!(switch_out.sample_sw && switch_out.discharge_sw))
    else $error("sampling and discharge switches closed together");
  AST_SW_GAP: assert property ($rose(switch_out.discharge_sw) |-> !$past(switch_out.sample_sw))
    else $error("discharge closed straight after sampling");
  AST_SAMPLE_PHASE: assert property (switch_out.sample_sw |->
    converting_out && switch_out.mod_clk)
    else $error("sampling switches closed outside a conversion");
  AST_MOD_PERIOD: assert property (rise && seen_q |-> per_q == 16'(4 * OSC_DIV))
    else $error("modulator period is not four oscillator ticks");
  AST_IDLE: assert property (!converting_out && !$past(converting_out) |-> switch_out == '0)
    else $error("switches active while powered down");
  AST_CONV_LEN: assert property ($fell(converting_out) |->
    run_q != 0 && run_q % (4 * OSC_DIV) == 0)
    else $error("conversion not a whole number of modulator periods");
  AST_ROUTE: assert property (!$past(sys_rst_in) |-> $onehot(route_out.pos_sel) &&
    (route_out.neg_gnd ? route_out.neg_sel == 4'h0 : $onehot(route_out.neg_sel)))
    else $error("illegal input routing");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
endmodule // acs_seq_chk

bind acs_sequencer acs_seq_chk #(.OSC_DIV(OSC_DIV)) u_seq_chk (.core_clk_in, .sys_rst_in,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .route_out, .switch_out, .converting_out);

// file: verif/acs_mod_model.sv
// behavioural modulator beside the sequencer: turns an input level into a bitstream
// assumes the switch outputs of the sequencer and its core clock
module acs_mod_model (
  input  wire logic                 clk_in,      // core clock
  input  wire logic                 rst_in,      // reset
  input  wire acs_pkg::acs_switch_t switch_in,   // switch controls
  input  wire logic                 level_in,    // input sign, 1 positive
  output logic                      mod_bit_out  // bitstream
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] idle_q;

  // ============================================================
  // input is taken only while the sampling switches are closed; when idle the line
  // toggles so a stale bit is never mistaken for a held one
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      idle_q      <= 3'h7;
      mod_bit_out <= 1'b0;
    end
    else if (switch_in.sample_sw)
    begin
      idle_q      <= 3'h0;
      mod_bit_out <= level_in;
    end
    else if (idle_q != 3'h7)
      idle_q <= idle_q + 3'h1;
    else
      mod_bit_out <= ~mod_bit_out;
  end
endmodule // acs_mod_model

// file: verif/adc_conversion_sequencer_tb_top.sv
// self-checking bench of the conversion sequencer over axi4-lite
// assumes OSC_DIV 1 and rate code 6, so one conversion lasts 300 core cycles
module adc_conversion_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CLEN = 300; // 75 periods of 4 ticks

  logic                 core_clk_in, sys_rst_in, ce_in, mod_bit_in, lvl, conv_q;
  logic                 s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                 s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                 s_axi_rvalid, s_axi_rready;
  logic [31:0]          s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]           s_axi_wstrb;
  logic [1:0]           s_axi_bresp, s_axi_rresp;
  acs_pkg::acs_route_t  route_out;
  acs_pkg::acs_switch_t switch_out;
  logic                 converting_out;
  int                   fail_count, checks, seed, hi_n, lo_n;
  logic [33:0]          rdq[$];
  int                   lenq[$], gapq[$];

  // ============================================================
  // clock, design and modulator
  initial
  begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end

  acs_sequencer #(.OSC_DIV(1), .HAS_MUX(1'b1)) DUT (.core_clk_in, .sys_rst_in, .ce_in,
    .mod_bit_in, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .route_out, .switch_out, .converting_out);

  acs_mod_model u_mod (.clk_in(core_clk_in), .rst_in(sys_rst_in), .switch_in(switch_out),
    .level_in(lvl), .mod_bit_out(mod_bit_in));

  // ============================================================
  // compares, closing and bus tasks
  task automatic cmp_val(input logic [33:0] got, input logic [33:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= {3'($random(seed)), 1'b1};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever
    begin
      @(posedge core_clk_in);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
  endtask

  // expected response and data are noted before the request goes out
  task automatic rd(input logic [31:0] a, input logic [1:0] r, input logic [31:0] d);
    @(posedge core_clk_in);
    rdq.push_back({r, d});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever
    begin
      @(posedge core_clk_in);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
  endtask

  function automatic acs_pkg::acs_route_t exp_route(input int s);
    exp_route = '0;
    if (s >= 4)
    begin
      exp_route.pos_sel = 4'h1 << (s - 4);
      exp_route.neg_gnd = 1'b1;
    end
    else
    begin
      exp_route.pos_sel = (s == 3) ? 4'h4 : (s == 2) ? 4'h2 : 4'h1;
      exp_route.neg_sel = (s == 0) ? 4'h2 : 4'h8;
    end
  endfunction

  // ============================================================
  // monitor: read data, conversion lengths and gaps, each against the oldest note;
  // a conversion nobody asked for meets an empty queue and fails
  always @(posedge core_clk_in)
  begin
    if (s_axi_rvalid && s_axi_rready)
      cmp_val({s_axi_rresp, s_axi_rdata}, rdq.size() ? rdq.pop_front() : '1);
    if (conv_q && !converting_out)
    begin
      cmp_val(hi_n, lenq.size() ? lenq.pop_front() : -1);
      hi_n = 0;
    end
    if (!conv_q && converting_out && gapq.size())
      cmp_val(lo_n, gapq.pop_front());
    hi_n += converting_out;
    lo_n = converting_out ? 0 : lo_n + 1;
    conv_q = converting_out;
  end

  // ============================================================
  // watchdog sized well above the roughly 4700 cycles of the sequence
  initial
  begin
    repeat (30000) @(posedge core_clk_in);
    fail_count++;
    tally_and_finish;
  end

  // ============================================================
  // main sequence
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = 100'h0;
    {fail_count, checks, hi_n, lo_n, conv_q, lvl} = 0;
    seed = 32'hd25b495c;
    ce_in = 1'b1;
    sys_rst_in = 1'b1;
    repeat (3) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    rd(32'h0, 2'h0, 32'h20);
    rd(32'h4, 2'h0, 32'h0);
    rd(32'h8, 2'h0, 32'h0);
    rd(32'hC, 2'h2, 32'h0);
    repeat (300) @(posedge core_clk_in);
    for (int s = 0; s < 8; s++)
    begin
      lvl <= 1'($random(seed));
      lenq.push_back(CLEN);
      wr(32'h0, 32'hB0 | 32'(s));
      repeat (150) @(posedge core_clk_in);
      cmp_val(route_out, exp_route(s));
      while (lenq.size()) @(posedge core_clk_in);
      rd(32'h4, 2'h0, lvl ? 32'h7FF : 32'h801);
      rd(32'h8, 2'h0, 32'h0);
      rd(32'h0, 2'h0, 32'h30 | 32'(s));
    end
    // continuous run of four, input sign flipped after the first
    lvl <= 1'b1;
    repeat (4) lenq.push_back(CLEN);
    wr(32'h0, 32'hF0);
    repeat (2) @(negedge core_clk_in); // first start of the run follows a long idle gap
    gapq = '{1, 1, 1};
    while (lenq.size() > 3) @(posedge core_clk_in);
    lvl <= 1'b0;
    while (lenq.size() > 1) @(posedge core_clk_in);
    rd(32'h4, 2'h0, 32'h801);
    wr(32'h0, 32'h30);
    while (lenq.size()) @(posedge core_clk_in);
    repeat (700) @(posedge core_clk_in);
    rd(32'h8, 2'h0, 32'h0);
    cmp_val(gapq.size(), 0);
    tally_and_finish;
  end
endmodule // adc_conversion_sequencer_tb_top
